// File: logic/rpbs_cfg_engine.sv
// Configuration engine with transaction ROM, register port and interrupt
// ==========================================================
// How it works
// - Each ROM transaction is a pair of words, a header then a 32-bit payload.
// - Headers sit at even ROM addresses and payloads at the odd address after them.
// - For configuration reads and plain messages the payload word exists but is ignored.
// - A two-bit header field picks message, message with data, config write or config read.
// - Message headers give routing and code; config headers give function, register and BE.
// - Each value loaded into the ROM fills exactly one location.
// - The engine raises setup_complete at the end, and setup_error too on failure.
// - Each config transaction waits for its completion, with no timeout.
`default_nettype none
module rpbs_cfg_engine
  import rpbs_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // Link and test master
  input  wire logic              link_is_up,
  input  wire logic              begin_setup_pulse,
  output logic                   setup_complete,
  output logic                   setup_error,
  // Transaction stream out
  output logic                   tx_valid,
  input  wire logic              tx_ready,
  output logic [1:0]             tx_type,
  output logic [ROUTE_W-1:0]     tx_route,
  output logic [CODE_W-1:0]      tx_code,
  output logic [FUNC_W-1:0]      tx_func,
  output logic [REG_W-1:0]       tx_regnum,
  output logic [BE_W-1:0]        tx_first_be,
  output logic [DW-1:0]          tx_data,
  // Completion in
  input  wire logic              cpl_valid,
  input  wire logic              cpl_match,
  // Register port
  input  wire logic [AW-1:0]     reg_addr,
  input  wire logic [DW-1:0]     reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [DW-1:0]          reg_rdata,
  // Interrupt
  output logic                   irq
);

  // ==========================================================
  // Storage and state
  logic [DW-1:0]       rom_mem [ROM_DEPTH];
  logic [ROM_AW-1:0]   load_addr;
  logic [ENT_W-1:0]    entry_count;
  logic [ENT_W-1:0]    entry_idx;
  logic [DW-1:0]       tx_hdr;
  logic [IRQ_W-1:0]    irq_stat;
  logic [IRQ_W-1:0]    irq_mask;
  rpbs_state_t         state;
  rpbs_state_t         next_state;
  logic                start_req;
  logic                last_entry;
  logic                is_cfg;
  logic                has_data;
  logic                wr_ctrl;
  logic                wr_rom;
  logic [ROM_AW-1:0]   hdr_addr;
  logic [ROM_AW-1:0]   pay_addr;
  logic [ENT_W-1:0]    next_idx;
  logic                run_end;

  // Strobe decode
  assign wr_ctrl   = reg_wr && (reg_addr == OFF_CTRL);
  assign wr_rom    = reg_wr && (reg_addr == OFF_ROM_DATA);
  assign start_req = link_is_up && (begin_setup_pulse || (wr_ctrl && reg_wdata[CTRL_START]));
  assign next_idx  = entry_idx + 1'b1;
  assign last_entry = (next_idx >= entry_count);
  // Header at even address, payload at the odd one after it
  assign hdr_addr  = {entry_idx[ROM_AW-2:0], 1'b0};
  assign pay_addr  = {entry_idx[ROM_AW-2:0], 1'b1};
  // A run ends on entering done, or on a zero-entry restart while already done
  assign run_end   = (next_state == ST_DONE) && ((state != ST_DONE) || start_req);

  // ==========================================================
  // Header field decode from the held header word
  assign tx_type     = tx_hdr[TYPE_LSB +: 2];
  assign tx_route    = tx_hdr[ROUTE_LSB +: ROUTE_W];
  assign tx_code     = tx_hdr[CODE_LSB +: CODE_W];
  assign tx_func     = tx_hdr[FUNC_LSB +: FUNC_W];
  assign tx_regnum   = tx_hdr[REG_LSB +: REG_W];
  assign tx_first_be = tx_hdr[BE_LSB +: BE_W];
  assign is_cfg      = tx_hdr[TYPE_LSB + 1];
  assign tx_valid    = (state == ST_SEND);

  // Payload counts only for writes and messages with data
  always_comb begin
    unique case (rom_mem[hdr_addr][TYPE_LSB +: 2])
      TT_MSG_DATA, TT_CFG_WR: has_data = 1'b1;
      default:                has_data = 1'b0;
    endcase
  end

  // ==========================================================
  // ROM loader: one write fills one location, address steps on
  always_ff @(posedge clk_sys) begin
    if (wr_rom) begin
      rom_mem[load_addr] <= reg_wdata;
    end
  end

  // Loader address register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      load_addr <= '0;
    end else if (reg_wr && (reg_addr == OFF_ROM_ADDR)) begin
      load_addr <= reg_wdata[ROM_AW-1:0];
    end else if (wr_rom) begin
      load_addr <= load_addr + 1'b1;
    end
  end

  // Entry count, clipped to what the ROM holds
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      entry_count <= COUNT_RST;
    end else if (reg_wr && (reg_addr == OFF_COUNT)) begin
      entry_count <= (reg_wdata[ENT_W-1:0] > ENT_MAX) ? ENT_MAX : reg_wdata[ENT_W-1:0];
    end
  end

  // ==========================================================
  // Sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE:  if (start_req) next_state = (entry_count == COUNT_RST) ? ST_DONE : ST_ISSUE;
      ST_ISSUE: next_state = ST_SEND;
      ST_SEND: begin
        if (tx_ready) begin
          if (is_cfg) next_state = ST_WAIT;
          else if (last_entry) next_state = ST_DONE;
          else next_state = ST_ISSUE;
        end
      end
      ST_WAIT: begin
        // No timeout: wait here until a completion shows up
        if (cpl_valid) begin
          if (!cpl_match || last_entry) next_state = ST_DONE;
          else next_state = ST_ISSUE;
        end
      end
      ST_DONE:  if (start_req) next_state = (entry_count == COUNT_RST) ? ST_DONE : ST_ISSUE;
      default:  next_state = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Entry index walks upward one pair at a time
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      entry_idx <= '0;
    end else if (start_req && (state == ST_IDLE || state == ST_DONE)) begin
      entry_idx <= '0;
    end else if (next_state == ST_ISSUE && (state == ST_SEND || state == ST_WAIT)) begin
      entry_idx <= next_idx;
    end
  end

  // Fetch header and payload pair into the output holding registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_hdr  <= WORD_ZERO;
      tx_data <= WORD_ZERO;
    end else if (state == ST_ISSUE) begin
      tx_hdr  <= rom_mem[hdr_addr];
      tx_data <= has_data ? rom_mem[pay_addr] : WORD_ZERO;
    end
  end

  // Completion and error flags, cleared by a new run; a zero-entry restart reports afresh
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      setup_complete <= 1'b0;
      setup_error    <= 1'b0;
    end else if (run_end) begin
      setup_complete <= 1'b1;
      setup_error    <= (state == ST_WAIT) && !cpl_match;
    end else if (next_state == ST_ISSUE) begin
      setup_complete <= 1'b0;
      setup_error    <= 1'b0;
    end
  end

  // ==========================================================
  // Interrupts: sticky status, set wins over write-one-to-clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= IRQ_RST;
    end else begin
      irq_stat <= (irq_stat & ~((reg_wr && reg_addr == OFF_IRQ_STAT) ?
                   reg_wdata[IRQ_W-1:0] : IRQ_RST))
                | {(state == ST_WAIT) && (next_state == ST_DONE) && !cpl_match,
                   run_end};
    end
  end

  // Interrupt mask
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= IRQ_RST;
    end else if (reg_wr && (reg_addr == OFF_IRQ_MASK)) begin
      irq_mask <= reg_wdata[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // Read data, valid the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= WORD_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= WORD_ZERO;
      unique case (reg_addr)
        OFF_COUNT:    reg_rdata[ENT_W-1:0] <= entry_count;
        OFF_STATUS: begin
          reg_rdata[ST_BUSY]                    <= (state != ST_IDLE) && (state != ST_DONE);
          reg_rdata[ST_COMPLETE]                <= setup_complete;
          reg_rdata[ST_ERROR]                   <= setup_error;
          reg_rdata[ST_IDX_LSB +: ENT_W]        <= entry_idx;
        end
        OFF_IRQ_STAT: reg_rdata[IRQ_W-1:0] <= irq_stat;
        OFF_IRQ_MASK: reg_rdata[IRQ_W-1:0] <= irq_mask;
        OFF_ROM_ADDR: reg_rdata[ROM_AW-1:0] <= load_addr;
        OFF_ROM_DATA: reg_rdata <= rom_mem[load_addr];
        default:      reg_rdata <= WORD_ZERO;
      endcase
    end else begin
      reg_rdata <= WORD_ZERO;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  pair_fetch_a: assert property (state == ST_ISSUE |=>
    tx_hdr == $past(rom_mem[hdr_addr])) else $error("header not from even word");
  even_odd_a: assert property (state == ST_ISSUE && has_data |=>
    tx_data == $past(rom_mem[pay_addr])) else $error("payload not from odd word");
  payload_ignored_a: assert property (tx_valid && (tx_type == TT_MSG || tx_type == TT_CFG_RD)
    |-> tx_data == WORD_ZERO) else $error("ignored payload leaked");
  // Fields checked against the ROM pair of the current entry, not the held copy
  type_field_a: assert property (tx_valid |->
    tx_type == rom_mem[hdr_addr][TYPE_LSB +: 2]) else $error("type field wrong");
  cfg_fields_a: assert property (tx_valid && is_cfg |->
    tx_first_be == rom_mem[hdr_addr][BE_LSB +: BE_W] &&
    tx_regnum == rom_mem[hdr_addr][REG_LSB +: REG_W] &&
    tx_func == rom_mem[hdr_addr][FUNC_LSB +: FUNC_W]) else $error("config fields wrong");
  msg_fields_a: assert property (tx_valid && !is_cfg |->
    tx_route == rom_mem[hdr_addr][ROUTE_LSB +: ROUTE_W] &&
    tx_code == rom_mem[hdr_addr][CODE_LSB +: CODE_W]) else $error("message fields wrong");
  rom_load_a: assert property (wr_rom |=>
    rom_mem[$past(load_addr)] == $past(reg_wdata) && load_addr == $past(load_addr) + 1'b1)
    else $error("ROM load slip");
  error_flag_a: assert property (setup_error |-> setup_complete)
    else $error("error without complete");
  bad_cpl_a: assert property (state == ST_WAIT && cpl_valid && !cpl_match |=>
    setup_error && state == ST_DONE) else $error("bad completion not reported");
  cpl_wait_a: assert property (state == ST_WAIT && !cpl_valid |=>
    state == ST_WAIT && !tx_valid) else $error("left wait without completion");
  ascend_a: assert property (state == ST_SEND && tx_ready && !is_cfg && !last_entry
    |=> entry_idx == $past(entry_idx) + 1'b1 ##1 tx_valid) else $error("entry order slip");

  msg_no_wait_a: assert property (state == ST_SEND && tx_ready && !is_cfg
    |=> state != ST_WAIT) else $error("message waited for completion");
  run_start_a: assert property (start_req && (state == ST_IDLE || state == ST_DONE)
    && entry_count != COUNT_RST |=> state == ST_ISSUE && entry_idx == '0)
    else $error("run did not start at entry zero");
  done_report_a: assert property (run_end |=>
    setup_complete && irq_stat[IRQ_DONE]) else $error("run end not reported");
  zero_rerun_a: assert property (start_req && state == ST_DONE
    && entry_count == COUNT_RST |=> setup_complete && !setup_error)
    else $error("zero-entry restart kept old result");

  // Covers for the main runs
  sequence bad_cpl_event;
    state == ST_WAIT && cpl_valid && !cpl_match;
  endsequence
  run_cover: cover property (state == ST_IDLE && start_req ##[1:200] setup_complete);
  err_cover: cover property (bad_cpl_event);
  msg_cover: cover property (tx_valid && tx_ready && tx_type == TT_MSG_DATA);
  rerun_cover: cover property (start_req && state == ST_DONE && entry_count == COUNT_RST);

endmodule
`default_nettype wire

// File: common/rpbs_pkg.sv
// Constants, field layouts and types shared by the bring-up configuration engine
`default_nettype none
package rpbs_pkg;
  // ==========================================================
  // ROM geometry: two words per transaction
  localparam int ROM_AW    = 6;
  localparam int ROM_DEPTH = 64;
  localparam int ENT_W     = 6;
  localparam int DW        = 32;
  localparam logic [ENT_W-1:0] ENT_MAX = 6'h20;
  // ==========================================================
  // Register offsets on the plain register port
  localparam int AW = 8;
  localparam logic [AW-1:0] OFF_CTRL     = 8'h00;
  localparam logic [AW-1:0] OFF_COUNT    = 8'h04;
  localparam logic [AW-1:0] OFF_STATUS   = 8'h08;
  localparam logic [AW-1:0] OFF_IRQ_STAT = 8'h0C;
  localparam logic [AW-1:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [AW-1:0] OFF_ROM_ADDR = 8'h14;
  localparam logic [AW-1:0] OFF_ROM_DATA = 8'h18;
  // Control and status bit positions
  localparam int CTRL_START  = 0;
  localparam int ST_BUSY     = 0;
  localparam int ST_COMPLETE = 1;
  localparam int ST_ERROR    = 2;
  localparam int ST_IDX_LSB  = 8;
  localparam int IRQ_W       = 2;
  localparam int IRQ_DONE    = 0;
  localparam int IRQ_ERR     = 1;
  // Reset values
  localparam logic [ENT_W-1:0] COUNT_RST = 6'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST   = 2'h0;
  localparam logic [DW-1:0]    WORD_ZERO = 32'h0000_0000;
  // ==========================================================
  // Header word layout
  localparam int TYPE_LSB  = 0;
  localparam int ROUTE_LSB = 2;
  localparam int ROUTE_W   = 3;
  localparam int CODE_LSB  = 5;
  localparam int CODE_W    = 8;
  localparam int FUNC_LSB  = 2;
  localparam int FUNC_W    = 3;
  localparam int REG_LSB   = 5;
  localparam int REG_W     = 10;
  localparam int BE_LSB    = 15;
  localparam int BE_W      = 4;
  // Transaction types held in two header bits
  typedef enum logic [1:0] {
    TT_MSG      = 2'b00,
    TT_MSG_DATA = 2'b01,
    TT_CFG_WR   = 2'b10,
    TT_CFG_RD   = 2'b11
  } rpbs_ttype_t;
  // Engine states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ISSUE = 3'b001,
    ST_SEND  = 3'b010,
    ST_WAIT  = 3'b011,
    ST_DONE  = 3'b100
  } rpbs_state_t;
endpackage
`default_nettype wire

// File: testbench/rpbs_sink_model.sv
// Transaction sink and completion source on the far side of the engine
`default_nettype none
module rpbs_sink_model
  import rpbs_pkg::*;
(
  // Clock, reset and bench controls
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       slow,
  input  wire logic       bad,
  // Transaction stream
  input  wire logic       tx_valid,
  input  wire logic [1:0] tx_type,
  output logic            tx_ready,
  // Completions
  output logic            cpl_valid,
  output logic            cpl_match
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_cnt;
  // Random stalls when slow; one completion per config entry, none for messages
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_ready  <= 1'b0;
      cpl_valid <= 1'b0;
      cpl_match <= 1'b0;
      wait_cnt = 0;
    end else begin
      tx_ready  <= slow ? 1'($urandom() % 2) : 1'b1;
      cpl_valid <= (wait_cnt == 1);
      cpl_match <= (wait_cnt == 1) ? !bad : !cpl_match;
      if (wait_cnt > 0)
        wait_cnt = wait_cnt - 1;
      if (tx_valid && tx_ready && tx_type[1])
        wait_cnt = 3 + (slow ? int'($urandom() % 9) : 0);
    end
  end
endmodule
`default_nettype wire

// File: testbench/rpbs_cfg_engine_tb_top.sv
// Self-checking bench for the configuration engine
`default_nettype none
module rpbs_cfg_engine_tb_top
  import rpbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk_sys, rst_n, link_is_up, begin_setup_pulse, setup_complete;
  logic              setup_error, tx_valid, tx_ready, cpl_valid, cpl_match, reg_wr;
  logic              reg_rd, irq, slow, bad;
  logic [1:0]        tx_type;
  logic [ROUTE_W-1:0] tx_route;
  logic [CODE_W-1:0] tx_code;
  logic [FUNC_W-1:0] tx_func;
  logic [REG_W-1:0]  tx_regnum;
  logic [BE_W-1:0]   tx_first_be;
  logic [DW-1:0]     tx_data, reg_wdata, reg_rdata, v;
  logic [AW-1:0]     reg_addr;
  logic [63:0]       exp_q[$];
  logic [63:0]       e;
  logic [DW-1:0]     rom_m[ROM_DEPTH];
  int                failures, n_checks;
  rpbs_cfg_engine i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .link_is_up(link_is_up),
    .begin_setup_pulse(begin_setup_pulse), .setup_complete(setup_complete),
    .setup_error(setup_error), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_type(tx_type),
    .tx_route(tx_route), .tx_code(tx_code), .tx_func(tx_func), .tx_regnum(tx_regnum),
    .tx_first_be(tx_first_be), .tx_data(tx_data), .cpl_valid(cpl_valid),
    .cpl_match(cpl_match), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  rpbs_sink_model i_sink (.clk_sys(clk_sys), .rst_n(rst_n), .slow(slow), .bad(bad),
    .tx_valid(tx_valid), .tx_type(tx_type), .tx_ready(tx_ready), .cpl_valid(cpl_valid),
    .cpl_match(cpl_match));
  // ==========================================================
  // Reporting
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk_val(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t value got %h expected %h", $time, got, exp);
    end
  endtask
  // Accepted transaction against the model entry: fields are header slices
  task automatic chk_tx(input logic [63:0] m);
    logic [31:0] h;
    logic [31:0] d;
    h = m[31:0];
    d = (h[1:0] == TT_MSG || h[1:0] == TT_CFG_RD) ? WORD_ZERO : m[63:32];
    n_checks++;
    if ({tx_type, tx_route, tx_code, tx_func, tx_regnum, tx_first_be, tx_data} !==
        {h[1:0], h[4:2], h[12:5], h[4:2], h[14:5], h[18:15], d}) begin
      failures++;
      $display("[ERR] %0t transaction header %h data %h", $time, h, tx_data);
    end
  endtask
  // ==========================================================
  // Register port cycles
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] q);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Transaction monitor
  always @(posedge clk_sys) begin
    if (rst_n === 1'b1 && tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk_val(32'h0000_0001, 32'h0000_0000);
      end else begin
        e = exp_q.pop_front();
        chk_tx(e);
      end
    end
  end
  // ==========================================================
  // One run: load ROM, start, wait for the end, check flags and interrupt
  task automatic run(input int n, input logic b, input logic s, input logic by_reg);
    logic [31:0] h, d;
    int          stop = 0;
    bad  <= b;
    slow <= s;
    wr(OFF_ROM_ADDR, 32'h0000_0000);
    for (int k = 0; k < n; k++) begin
      h = $urandom();
      d = $urandom();
      rom_m[2*k]   = h;
      rom_m[2*k+1] = d;
      wr(OFF_ROM_DATA, h);
      wr(OFF_ROM_DATA, d);
      if (stop == 0)
        exp_q.push_back({d, h});
      if (b && h[1])
        stop = 1;
    end
    wr(OFF_COUNT, n);
    wr(OFF_IRQ_MASK, 32'h0000_0003);
    if (by_reg) begin
      wr(OFF_CTRL, 32'h0000_0001);
    end else begin
      @(posedge clk_sys);
      begin_setup_pulse <= 1'b1;
      @(posedge clk_sys);
      begin_setup_pulse <= 1'b0;
    end
    repeat (3) @(posedge clk_sys);
    for (int i = 0; i <= 4000 && setup_complete !== 1'b1; i++) begin
      if (i == 4000) begin
        failures++;
        close_out();
      end
      @(posedge clk_sys);
    end
    #1 chk_val(setup_error, stop);
    chk_val(exp_q.size(), 0);
    rd(OFF_STATUS, v);
    chk_val(v & 32'h0000_0007, {29'h0, stop[0], 2'b10});
    chk_val(irq, 1);
    rd(OFF_IRQ_STAT, v);
    chk_val(v, {30'h0, stop[0], 1'b1});
    wr(OFF_IRQ_MASK, 32'h0000_0000);
    #1 chk_val(irq, 0);
    wr(OFF_IRQ_STAT, 32'h0000_0003);
    rd(OFF_IRQ_STAT, v);
    chk_val(v, 0);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    failures = 0;
    n_checks = 0;
    void'($urandom(32'h0000_fb48));
    {rst_n, link_is_up, begin_setup_pulse, reg_wr, reg_rd, slow, bad} = '0;
    reg_addr  = '0;
    reg_wdata = '0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1 chk_val({setup_complete, setup_error, tx_valid, irq}, 0);
    @(posedge clk_sys);
    link_is_up <= 1'b1;
    run(4, 1'b0, 1'b0, 1'b0);
    run(12, 1'b0, 1'b1, 1'b1);
    run(8, 1'b1, 1'b1, 1'b0);
    run(0, 1'b0, 1'b0, 1'b0);
    run(32, 1'b0, 1'b0, 1'b0);
    // Start with the link down is ignored and the last result stands
    @(posedge clk_sys);
    link_is_up <= 1'b0;
    begin_setup_pulse <= 1'b1;
    @(posedge clk_sys);
    begin_setup_pulse <= 1'b0;
    repeat (6) @(posedge clk_sys);
    #1 chk_val({tx_valid, setup_complete}, 1);
    // ROM peek: header at even word, payload at odd word
    for (int j = 0; j < 6; j++) begin
      wr(OFF_ROM_ADDR, j);
      rd(OFF_ROM_DATA, v);
      chk_val(v, rom_m[j]);
    end
    @(posedge clk_sys);
    #1 chk_val(reg_rdata, 0);
    rd(8'hFC, v);
    chk_val(v, 0);
    close_out();
  end
endmodule
`default_nettype wire
